/* File: src/redirection_entry_defines.vh */
`ifndef REDIRECTION_ENTRY_DEFINES_VH
`define REDIRECTION_ENTRY_DEFINES_VH
// ==========================================================
// Register byte offsets
`define REG_ENTRY_LOW 12'h000
`define REG_ENTRY_HIGH 12'h004
`define REG_INPUT_STATUS 12'h008
// ==========================================================
// Entry low word field positions
`define BIT_MASK 16
`define BIT_TRIGGER 15
`define BIT_REMOTE 14
`define BIT_POLARITY 13
`define BIT_PENDING 12
`define BIT_DEST_MODE 11
`define VEC_MSB 7
`define DELMODE_MSB 10
`define DELMODE_LSB 8
// ==========================================================
// Entry high word destination field positions
`define DEST_MSB 31
`define DEST_LSB 24
`define DEST_PHYS_MSB 27
// ==========================================================
// Reset values
`define RESET_LOW 32'h0001_0000
`define RESET_HIGH 32'h0000_0000
`endif

/* File: src/redirection_entry_control.v */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "redirection_entry_defines.vh"
// Overview of operation
// - Mask bit 16 set blocks new messages for the input; a message already pending is still sent
// - Edges on a masked edge input are dropped, not remembered
// - Level changes on a masked level input alter no state
// - Masking after acceptance leaves the accepted interrupt alone
// - Unmasked edge or level is sent to the programmed destination
// - Trigger bit 15: one selects level, zero selects edge
// - Remote accept flag bit 14 sets when a level interrupt is accepted
// - Remote accept flag clears on end of interrupt with matching vector
// - Polarity bit 13: zero active high, one active low
// - Delivery pending bit 12 is read only, writes leave it
// - Delivery pending reads one while a message waits for the bus
// - Physical mode sends the 4-bit identifier from bits 56 to 59
// - Logical mode sends the 8-bit value from bits 56 to 63
module redirection_entry_control
(
  input wire sys_clk_in,
  input wire nrst_in,
  input wire [31:0] paddr_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire irq_pin_in,
  output wire msg_req_out,
  output reg [7:0] msg_vector_out,
  output reg [2:0] msg_delivery_mode_out,
  output reg msg_level_out,
  output reg msg_dest_mode_out,
  output reg [7:0] msg_dest_out,
  input wire msg_accept_in,
  input wire eoi_valid_in,
  input wire [7:0] eoi_vector_in
);

  // ==========================================================
  // Entry storage and status
  reg [31:0] entry_low;
  reg [31:0] entry_high;
  reg remote_accept_flag;
  reg delivery_pending_flag;
  reg pin_meta;
  reg pin_sync;
  reg active_prev;
  reg [31:0] next_entry_low;
  reg [31:0] next_entry_high;
  reg next_remote_accept_flag;
  reg next_delivery_pending_flag;
  reg next_active_prev;
  reg [7:0] next_msg_vector;
  reg [2:0] next_msg_delivery_mode;
  reg next_msg_level;
  reg next_msg_dest_mode;
  reg [7:0] next_msg_dest;

  // ==========================================================
  // Entry field decode
  wire mask_bit;
  wire level_mode;
  wire input_polarity_select;
  wire destination_mode_select;
  wire [7:0] vector;
  wire [2:0] delivery_mode;
  wire [7:0] logical_dest;
  wire [3:0] physical_dest;

  assign mask_bit = entry_low[`BIT_MASK];
  assign level_mode = entry_low[`BIT_TRIGGER];
  assign input_polarity_select = entry_low[`BIT_POLARITY];
  assign destination_mode_select = entry_low[`BIT_DEST_MODE];
  assign vector = entry_low[`VEC_MSB:0];
  assign delivery_mode = entry_low[`DELMODE_MSB:`DELMODE_LSB];
  assign logical_dest = entry_high[`DEST_MSB:`DEST_LSB];
  assign physical_dest = entry_high[`DEST_PHYS_MSB:`DEST_LSB];

  // ==========================================================
  // Input conditioning
  wire active;
  wire edge_seen;
  wire level_seen;
  wire trigger;
  wire inject;
  wire accepted;
  wire eoi_match;

  assign active = pin_sync ^ input_polarity_select;
  assign edge_seen = active & ~active_prev;
  assign level_seen = active & ~remote_accept_flag;
  assign trigger = level_mode ? level_seen : edge_seen;
  assign inject = trigger & ~mask_bit & ~delivery_pending_flag;
  assign accepted = delivery_pending_flag & msg_accept_in;
  assign eoi_match = eoi_valid_in & (eoi_vector_in == vector);

  // ==========================================================
  // APB slave decode
  wire access;
  wire wr;
  wire hit_low;
  wire hit_high;
  wire hit_stat;
  wire mapped;

  assign access = psel_in & penable_in;
  assign wr = access & pwrite_in;
  assign hit_low = paddr_in[11:0] == `REG_ENTRY_LOW;
  assign hit_high = paddr_in[11:0] == `REG_ENTRY_HIGH;
  assign hit_stat = paddr_in[11:0] == `REG_INPUT_STATUS;
  assign mapped = hit_low | hit_high | hit_stat;
  assign pready_out = 1'b1;
  assign pslverr_out = access & ~mapped;

  // ==========================================================
  // Byte lane enables
  wire [31:0] byte_en;
  wire [31:0] low_wmask;
  wire [31:0] lw;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1)
    begin : g_lane
      assign byte_en[lane*8+7:lane*8] = {8{pstrb_in[lane]}};
    end
  endgenerate

  // Writable bits of the low word; status bits are hardware owned
  assign low_wmask = 32'h0001_AFFF;
  assign lw = low_wmask & byte_en;

  // ==========================================================
  // Entry register update
  always @*
  begin
    next_entry_low = entry_low;
    next_entry_high = entry_high;
    if (wr && hit_low)
    begin
      next_entry_low = (entry_low & ~lw) | (pwdata_in & lw);
    end
    if (wr && hit_high)
    begin
      next_entry_high = (entry_high & ~byte_en) | (pwdata_in & byte_en);
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      entry_low <= `RESET_LOW;
      entry_high <= `RESET_HIGH;
    end
    else
    begin
      entry_low <= next_entry_low;
      entry_high <= next_entry_high;
    end
  end

  always @*
  begin
    prdata_out = 32'h0000_0000;
    if (hit_low)
    begin
      prdata_out = entry_low;
      prdata_out[`BIT_REMOTE] = remote_accept_flag;
      prdata_out[`BIT_PENDING] = delivery_pending_flag;
    end
    else if (hit_high)
      prdata_out = entry_high;
    else if (hit_stat)
      prdata_out = {31'h0000_0000, active};
  end

  // ==========================================================
  // Pin synchroniser and edge history
  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= irq_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Masked input looks active, so no edge survives the unmask
  always @*
  begin
    next_active_prev = active;
    if (mask_bit)
    begin
      next_active_prev = 1'b1;
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      active_prev <= 1'b0;
    end
    else
    begin
      active_prev <= next_active_prev;
    end
  end

  // ==========================================================
  // Delivery and acceptance tracking
  assign msg_req_out = delivery_pending_flag;

  always @*
  begin
    next_delivery_pending_flag = delivery_pending_flag;
    if (inject)
    begin
      next_delivery_pending_flag = 1'b1;
    end
    else if (accepted)
    begin
      next_delivery_pending_flag = 1'b0;
    end
  end

  // Accepted message is never withdrawn by a later mask
  always @*
  begin
    next_remote_accept_flag = remote_accept_flag;
    if (accepted && msg_level_out)
    begin
      next_remote_accept_flag = 1'b1;
    end
    else if (eoi_match)
    begin
      next_remote_accept_flag = 1'b0;
    end
  end

  // Message fields are captured at injection and held while pending
  always @*
  begin
    next_msg_vector = msg_vector_out;
    next_msg_delivery_mode = msg_delivery_mode_out;
    next_msg_level = msg_level_out;
    next_msg_dest_mode = msg_dest_mode_out;
    next_msg_dest = msg_dest_out;
    if (inject)
    begin
      next_msg_vector = vector;
      next_msg_delivery_mode = delivery_mode;
      next_msg_level = level_mode;
      next_msg_dest_mode = destination_mode_select;
      if (destination_mode_select)
      begin
        next_msg_dest = logical_dest;
      end
      else
      begin
        next_msg_dest = {4'h0, physical_dest};
      end
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      delivery_pending_flag <= 1'b0;
      remote_accept_flag <= 1'b0;
    end
    else
    begin
      delivery_pending_flag <= next_delivery_pending_flag;
      remote_accept_flag <= next_remote_accept_flag;
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      msg_vector_out <= 8'h00;
      msg_delivery_mode_out <= 3'h0;
      msg_level_out <= 1'b0;
      msg_dest_mode_out <= 1'b0;
      msg_dest_out <= 8'h00;
    end
    else
    begin
      msg_vector_out <= next_msg_vector;
      msg_delivery_mode_out <= next_msg_delivery_mode;
      msg_level_out <= next_msg_level;
      msg_dest_mode_out <= next_msg_dest_mode;
      msg_dest_out <= next_msg_dest;
    end
  end

endmodule // redirection_entry_control

/* File: bench/local_unit_model.sv */
`timescale 1ns/1ps
module local_unit_model
(
  input wire clk_in,
  input wire req_in,
  input wire [7:0] vec_in,
  input wire stall_in,
  input wire eoi_go_in,
  output reg accept_out = 1'b0,
  output reg eoi_valid_out = 1'b0,
  output reg [7:0] eoi_vector_out = 8'h00
);
  // Accepts any destination unless stalled; sends end of interrupt on command
  always @(posedge clk_in)
  begin
    accept_out <= req_in && !stall_in && !accept_out;
    eoi_valid_out <= eoi_go_in;
    if (req_in && !stall_in && !accept_out)
      eoi_vector_out <= vec_in;
  end
endmodule // local_unit_model

/* File: bench/redirection_entry_checker.sv */
`timescale 1ns/1ps
module redirection_entry_checker
(
  input wire sys_clk_in, nrst_in, psel_in, penable_in, pwrite_in,
  input wire msg_req_out, msg_accept_in, msg_level_out,
  input wire msg_dest_mode_out, eoi_valid_in,
  input wire [31:0] paddr_in, prdata_out,
  input wire [7:0] msg_dest_out, msg_vector_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  wire rd = psel_in && penable_in && !pwrite_in && paddr_in == 32'h0;
  sequence take_s;
    msg_req_out && msg_accept_in;
  endsequence
  sequence wait_s;
    msg_req_out && !msg_accept_in;
  endsequence
  accept_drop_a: assert property (take_s |=> !msg_req_out)
    else $error("request kept");
  pending_hold_a: assert property (wait_s |=> msg_req_out)
    else $error("request lost");
  vector_hold_a: assert property (wait_s |=> $stable(msg_vector_out))
    else $error("vector moved");
  dest_hold_a: assert property (wait_s |=> $stable(msg_dest_out))
    else $error("dest moved");
  phys_dest_a: assert property
    (msg_req_out && !msg_dest_mode_out |-> msg_dest_out[7:4] == 4'h0)
    else $error("dest upper set");
  status_read_a: assert property (rd |-> prdata_out[12] == msg_req_out)
    else $error("status wrong");
  ro_bits_a: assert property (rd |-> prdata_out[31:17] == 15'h0)
    else $error("reserved set");
  level_hold_a: assert property
    (take_s ##0 msg_level_out ##1 !eoi_valid_in |=> !msg_req_out)
    else $error("level refired");
endmodule // redirection_entry_checker
bind redirection_entry_control redirection_entry_checker u_chk (.*);

/* File: bench/test_redirection_entry_control.sv */
`timescale 1ns/1ps
module test_redirection_entry_control;
  reg clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, pin = 0;
  reg stall = 1, eoi_go = 0;
  reg [31:0] paddr = 0, pwdata = 0, rdat;
  wire [31:0] prdata;
  wire rdy, req, acc, eoi_v, lvl, dmode;
  wire [7:0] vec, dest, eoi_vec;
  integer fails = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  redirection_entry_control u_dut (.sys_clk_in(clk), .nrst_in(nrst),
    .paddr_in(paddr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
    .pready_out(rdy), .pslverr_out(), .irq_pin_in(pin),
    .msg_req_out(req), .msg_vector_out(vec), .msg_delivery_mode_out(),
    .msg_level_out(lvl), .msg_dest_mode_out(dmode), .msg_dest_out(dest),
    .msg_accept_in(acc), .eoi_valid_in(eoi_v), .eoi_vector_in(eoi_vec));
  local_unit_model u_far (.clk_in(clk), .req_in(req), .vec_in(vec),
    .stall_in(stall), .eoi_go_in(eoi_go), .accept_out(acc),
    .eoi_valid_out(eoi_v), .eoi_vector_out(eoi_vec));
  task complete_run;
  begin
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task apb(input [31:0] a, input w, input [31:0] d);
  begin
    @(posedge clk) psel <= 1'b1;
    paddr <= a;
    pwr <= w;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rdat = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  end
  endtask
  task wait_req(input v);
    while (req !== v) @(posedge clk);
  endtask
  task t_edge;
  begin
    apb(32'h0, 1'b0, 32'h0);
    chk(rdat, 32'h0001_0000);
    @(posedge clk) pin <= 1'b1;
    apb(32'h4, 1'b1, 32'ha500_0000);
    apb(32'h0, 1'b1, 32'h0000_5030);
    repeat (6) @(posedge clk);
    chk({31'h0, req}, 32'h0);
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    pin <= 1'b1;
    wait_req(1'b1);
    chk({16'h0, dest, vec}, 32'h0000_0530);
    apb(32'h0, 1'b0, 32'h0);
    chk(rdat & 32'hffff_bfff, 32'h0000_1030);
    stall <= 1'b0;
    wait_req(1'b0);
    apb(32'h0, 1'b0, 32'h0);
    chk(rdat & 32'hffff_bfff, 32'h0000_0030);
  end
  endtask
  task t_level;
  begin
    apb(32'h0, 1'b1, 32'h0000_a841);
    pin <= 1'b0;
    wait_req(1'b1);
    chk({22'h0, lvl, dmode, dest}, 32'h0000_03a5);
    wait_req(1'b0);
    apb(32'h0, 1'b1, 32'h0001_a841);
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    apb(32'h0, 1'b0, 32'h0);
    chk(rdat, 32'h0001_e841);
    apb(32'h0, 1'b1, 32'h0000_a841);
    eoi_go <= 1'b1;
    @(posedge clk) eoi_go <= 1'b0;
    apb(32'h0, 1'b0, 32'h0);
    chk(rdat, 32'h0000_a841);
    pin <= 1'b0;
    wait_req(1'b1);
    chk({24'h0, vec}, 32'h0000_0041);
  end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails = fails + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_edge;
    t_level;
    complete_run;
  end
endmodule // test_redirection_entry_control
